/* File: verilog/ntf_formatter.v */
// NRZI tape block formatter: write framing, read checking, Avalon-MM registers
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "ntf_defines.vh"
module ntf_formatter #(
  parameter CHAR_CYC_200 = `NTF_CHAR_CYC(`NTF_CPI_200),
  parameter CHAR_CYC_556 = `NTF_CHAR_CYC(`NTF_CPI_556),
  parameter CHAR_CYC_800 = `NTF_CHAR_CYC(`NTF_CPI_800),
  parameter GAP_FM_CYC   = `NTF_GAP_CYC(`NTF_GAP_FM_MIL),
  parameter GAP_IBG7_CYC = `NTF_GAP_CYC(`NTF_IBG7_MIL),
  parameter GAP_IBG9_CYC = `NTF_GAP_CYC(`NTF_IBG9_MIL)
) (
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire [4:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  output wire [1:0]  tape_sel_o,
  output reg  [8:0]  tape_wr_o,
  output reg         tape_wr_strobe_o,
  output reg         tape_gap_o,
  input  wire [8:0]  tape_rd_i,
  input  wire        tape_rd_strobe_i,
  output reg  [7:0]  rd_data_o,
  output reg         rd_strobe_o,
  output reg         hard_err_o,
  output reg         block_end_o,
  output reg         file_mark_o
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_PRE  = 6'h02;
  localparam [5:0] S_DATA = 6'h04;
  localparam [5:0] S_FMC  = 6'h08;
  localparam [5:0] S_CHK  = 6'h10;
  localparam [5:0] S_POST = 6'h20;

  // ==================================================
  // Character mapping and cyclic check step
  function [8:0] ntf_map;
    input [7:0] d;
    input       nine;
    input       even_p;
    reg   [8:0] c;
    integer     i;
    begin
      c = 9'h000;
      for (i = 0; i < 8; i = i + 1) begin
        c[i] = d[7 - i];
      end
      if (!nine) begin
        c[1:0] = 2'h0;
      end
      if (nine) begin
        c[8] = ~^d;
      end else if (even_p) begin
        c[8] = ^d[5:0];
      end else begin
        c[8] = ~^d[5:0];
      end
      ntf_map = c;
    end
  endfunction

  function [8:0] ntf_crc_step;
    input [8:0] crc;
    input [8:0] ch;
    reg   [8:0] x;
    reg   [8:0] n;
    begin
      x = crc ^ ch;
      n = {x[7:0], x[8]};
      if (x[8]) begin
        n = n ^ `NTF_CRC_TAPS;
      end
      ntf_crc_step = n;
    end
  endfunction

  // ==================================================
  // Registers and bus slave
  reg  [7:0]  ctrl;
  reg  [7:0]  hold;
  reg         hold_full;
  reg         end_req;
  reg         fm_req;
  reg         start_req;
  reg         st_under;
  reg         st_short;
  reg         st_perr;
  reg         st_terr;
  reg         st_fmark;
  reg         st_bend;
  reg         rd_ack;
  reg  [5:0]  state;
  reg  [7:0]  rd_last_data;

  wire nine   = ctrl[`NTF_CTRL_NINE];
  wire even_p = ctrl[`NTF_CTRL_EVEN];
  wire [1:0] dens = ctrl[`NTF_CTRL_DENS];
  wire busy = (state != S_IDLE);

  wire wr_cyc = avs_write_i & avs_byteenable_i[0];
  wire wr_wdata = wr_cyc & (avs_address_i == `NTF_REG_WDATA);
  wire wr_stall = wr_wdata & hold_full;
  wire wr_take = wr_cyc & ~wr_stall;
  wire wr_ctrl = wr_take & (avs_address_i == `NTF_REG_CTRL);
  wire wr_cmd = wr_take & (avs_address_i == `NTF_REG_CMD);
  wire [7:0] wbyte = avs_writedata_i[7:0];
  wire clr = wr_cmd & wbyte[`NTF_CMD_CLR];

  assign avs_waitrequest_o = (avs_read_i & ~rd_ack) | wr_stall;
  assign tape_sel_o = ctrl[`NTF_CTRL_SEL];

  wire [7:0] status = {st_bend, st_fmark, st_terr, st_perr,
                       st_short, st_under, hold_full, busy};

  reg [7:0] rd_mux;
  always @* begin
    case (avs_address_i)
      `NTF_REG_CTRL:   rd_mux = ctrl;
      `NTF_REG_WDATA:  rd_mux = hold;
      `NTF_REG_STATUS: rd_mux = status;
      `NTF_REG_RDATA:  rd_mux = rd_last_data;
      default:         rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_ack <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      ctrl <= `NTF_CTRL_RST;
    end else begin
      rd_ack <= avs_read_i & ~rd_ack;
      if (avs_read_i & ~rd_ack) begin
        avs_readdata_o <= {24'h00_0000, rd_mux};
      end
      if (wr_ctrl & ~busy) begin
        ctrl <= wbyte;
      end
    end
  end

  // ==================================================
  // Character period tick
  reg  [15:0] tick_cnt;
  reg         tick;
  reg  [15:0] per_cyc;
  always @* begin
    if (nine) begin
      per_cyc = CHAR_CYC_800[15:0];
    end else if (dens == `NTF_DENS_200) begin
      per_cyc = CHAR_CYC_200[15:0];
    end else if (dens == `NTF_DENS_556) begin
      per_cyc = CHAR_CYC_556[15:0];
    end else begin
      per_cyc = CHAR_CYC_800[15:0];
    end
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (tick_cnt >= per_cyc - 16'h0001) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // ==================================================
  // Write sequencer
  reg  [31:0] gap_cnt;
  reg  [3:0]  chk_per;
  reg  [8:0]  crc;
  reg  [8:0]  lrc;
  reg  [1:0]  blk_n;
  reg         fm_op;
  wire [8:0]  hold_ch = ntf_map(hold, nine, even_p);
  wire [8:0]  crc_out = crc ^ `NTF_CRC_INV;
  wire [8:0]  fm_ch = nine ? `NTF_FM9 : `NTF_FM7;
  wire [3:0]  chk_nxt = chk_per + 4'h1;

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= S_IDLE;
      hold <= 8'h00;
      hold_full <= 1'b0;
      end_req <= 1'b0;
      fm_req <= 1'b0;
      start_req <= 1'b0;
      gap_cnt <= 32'h0000_0000;
      chk_per <= 4'h0;
      crc <= 9'h000;
      lrc <= 9'h000;
      blk_n <= 2'h0;
      fm_op <= 1'b0;
      tape_wr_o <= 9'h000;
      tape_wr_strobe_o <= 1'b0;
      tape_gap_o <= 1'b0;
      st_under <= 1'b0;
      st_short <= 1'b0;
    end else begin
      tape_wr_strobe_o <= 1'b0;
      if (wr_take & (avs_address_i == `NTF_REG_WDATA)) begin
        hold <= wbyte;
        hold_full <= 1'b1;
      end
      if (wr_cmd & wbyte[`NTF_CMD_START]) begin
        start_req <= 1'b1;
        fm_req <= wbyte[`NTF_CMD_FMARK];
      end
      if (wr_cmd & wbyte[`NTF_CMD_END]) begin
        end_req <= 1'b1;
      end
      if (clr) begin
        st_under <= 1'b0;
        st_short <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          tape_gap_o <= 1'b0;
          crc <= 9'h000;
          lrc <= 9'h000;
          blk_n <= 2'h0;
          chk_per <= 4'h0;
          if (start_req) begin
            start_req <= 1'b0;
            fm_op <= fm_req;
            if (fm_req) begin
              gap_cnt <= GAP_FM_CYC;
              tape_gap_o <= 1'b1;
              state <= S_PRE;
            end else begin
              state <= S_DATA;
            end
          end
        end
        S_PRE: begin
          if (gap_cnt != 32'h0000_0000) begin
            gap_cnt <= gap_cnt - 32'h0000_0001;
          end else begin
            tape_gap_o <= 1'b0;
            state <= S_FMC;
          end
        end
        S_FMC: begin
          if (tick) begin
            tape_wr_o <= fm_ch;
            tape_wr_strobe_o <= 1'b1;
            lrc <= lrc ^ fm_ch;
            chk_per <= 4'h0;
            state <= S_CHK;
          end
        end
        S_DATA: begin
          if (tick) begin
            if (hold_full) begin
              tape_wr_o <= hold_ch;
              tape_wr_strobe_o <= 1'b1;
              hold_full <= 1'b0;
              lrc <= lrc ^ hold_ch;
              crc <= ntf_crc_step(crc, hold_ch);
              if (blk_n != `NTF_MIN_BLK) begin
                blk_n <= blk_n + 2'h1;
              end
            end else if (end_req) begin
              end_req <= 1'b0;
              chk_per <= 4'h1;
              if (blk_n != `NTF_MIN_BLK) begin
                st_short <= 1'b1;
              end
              state <= S_CHK;
            end else begin
              st_under <= 1'b1;
            end
          end
        end
        S_CHK: begin
          if (tick) begin
            chk_per <= chk_nxt;
            if (chk_nxt == `NTF_CHK1_PER) begin
              if (!nine) begin
                tape_wr_o <= lrc;
                tape_wr_strobe_o <= 1'b1;
                gap_cnt <= GAP_IBG7_CYC;
                tape_gap_o <= 1'b1;
                state <= S_POST;
              end else if (!fm_op) begin
                tape_wr_o <= crc_out;
                tape_wr_strobe_o <= 1'b1;
                lrc <= lrc ^ crc_out;
              end
            end else if (chk_nxt == `NTF_CHK2_PER) begin
              tape_wr_o <= lrc;
              tape_wr_strobe_o <= 1'b1;
              gap_cnt <= GAP_IBG9_CYC;
              tape_gap_o <= 1'b1;
              state <= S_POST;
            end
          end
        end
        S_POST: begin
          if (gap_cnt != 32'h0000_0000) begin
            gap_cnt <= gap_cnt - 32'h0000_0001;
          end else begin
            tape_gap_o <= 1'b0;
            end_req <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==================================================
  // Read checker
  reg  [5:0]  sil;
  reg         in_blk;
  reg         chk_ph;
  reg  [1:0]  rd_n;
  reg  [8:0]  rd_lrc;
  reg  [8:0]  rd_first;
  reg  [8:0]  rd_chk;
  reg  [7:0]  rd_byte;
  reg         rd_perr;
  reg  [5:0]  sil_lim;
  integer     k;

  always @* begin
    rd_byte = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      rd_byte[7 - k] = tape_rd_i[k];
    end
    if (!nine) begin
      rd_byte[7:6] = 2'h0;
    end
    if (nine) begin
      rd_perr = ~^tape_rd_i;
    end else if (even_p) begin
      rd_perr = ^{tape_rd_i[8], tape_rd_i[7:2]};
    end else begin
      rd_perr = ~^{tape_rd_i[8], tape_rd_i[7:2]};
    end
    if (!nine && dens == `NTF_DENS_200) begin
      sil_lim = `NTF_SIL_200;
    end else begin
      sil_lim = `NTF_SIL_LONG;
    end
  end

  wire is_chk = in_blk & (chk_ph | (sil >= `NTF_SIL_CHK));
  wire blk_done = in_blk & tick & ~tape_rd_strobe_i & (sil + 6'h01 >= sil_lim);
  wire mark_hit = (rd_n == 2'h1) & (rd_first == fm_ch) & (rd_chk == fm_ch);

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sil <= 6'h00;
      in_blk <= 1'b0;
      chk_ph <= 1'b0;
      rd_n <= 2'h0;
      rd_lrc <= 9'h000;
      rd_first <= 9'h000;
      rd_chk <= 9'h000;
      rd_data_o <= 8'h00;
      rd_last_data <= 8'h00;
      rd_strobe_o <= 1'b0;
      hard_err_o <= 1'b0;
      block_end_o <= 1'b0;
      file_mark_o <= 1'b0;
      st_perr <= 1'b0;
      st_terr <= 1'b0;
      st_fmark <= 1'b0;
      st_bend <= 1'b0;
    end else begin
      rd_strobe_o <= tape_rd_strobe_i;
      hard_err_o <= tape_rd_strobe_i & ~is_chk & rd_perr;
      block_end_o <= blk_done;
      file_mark_o <= blk_done & mark_hit;
      if (tape_rd_strobe_i) begin
        rd_data_o <= rd_byte;
        rd_last_data <= rd_byte;
        sil <= 6'h00;
        in_blk <= 1'b1;
        rd_lrc <= rd_lrc ^ tape_rd_i;
        if (is_chk) begin
          chk_ph <= 1'b1;
          rd_chk <= tape_rd_i;
        end else begin
          if (rd_n == 2'h0) begin
            rd_first <= tape_rd_i;
          end
          if (rd_n != `NTF_MIN_BLK) begin
            rd_n <= rd_n + 2'h1;
          end
        end
      end else if (tick & in_blk & (sil != 6'h3f)) begin
        sil <= sil + 6'h01;
      end
      if (blk_done) begin
        in_blk <= 1'b0;
        chk_ph <= 1'b0;
        rd_n <= 2'h0;
        rd_lrc <= 9'h000;
        sil <= 6'h00;
      end
      st_perr <= (st_perr & ~clr)
               | (tape_rd_strobe_i & ~is_chk & rd_perr);
      st_terr <= (st_terr & ~clr)
               | (blk_done & (rd_lrc != 9'h000));
      st_fmark <= (st_fmark & ~clr) | (blk_done & mark_hit);
      st_bend <= (st_bend & ~clr) | blk_done;
    end
  end

endmodule
`default_nettype wire

/* File: common/ntf_defines.vh */
// Constants, register map and timing for the NRZI tape block formatter
`ifndef NTF_DEFINES_VH
`define NTF_DEFINES_VH
// ==================================================
// Timing
`define NTF_CLK_HZ 100000000
`define NTF_IPS 75
`define NTF_CPI_200 200
`define NTF_CPI_556 556
`define NTF_CPI_800 800
`define NTF_CHAR_CYC(c) (`NTF_CLK_HZ / ((c) * `NTF_IPS))
`define NTF_GAP_FM_MIL 3560
`define NTF_IBG7_MIL 750
`define NTF_IBG9_MIL 600
`define NTF_GAP_CYC(m) (((m) * (`NTF_CLK_HZ / 1000) + `NTF_IPS - 1) / `NTF_IPS)
`define NTF_CHK1_PER 4'h4
`define NTF_CHK2_PER 4'h8
`define NTF_SIL_LONG 6'h1a
`define NTF_SIL_200 6'h0e
`define NTF_SIL_CHK 6'h02
`define NTF_MIN_BLK 2'h3
// ==================================================
// Register map, byte addresses
`define NTF_REG_CTRL 5'h00
`define NTF_REG_CMD 5'h04
`define NTF_REG_WDATA 5'h08
`define NTF_REG_STATUS 5'h0c
`define NTF_REG_RDATA 5'h10
`define NTF_CTRL_RST 8'h00
`define NTF_CTRL_NINE 0
`define NTF_CTRL_EVEN 1
`define NTF_CTRL_DENS 3:2
`define NTF_CTRL_SEL 5:4
`define NTF_CMD_START 0
`define NTF_CMD_FMARK 1
`define NTF_CMD_END 2
`define NTF_CMD_CLR 3
`define NTF_DENS_200 2'h0
`define NTF_DENS_556 2'h1
// ==================================================
// Channel patterns, bit i is channel i, bit 8 is P
`define NTF_FM9 9'h0c8
`define NTF_FM7 9'h0f0
`define NTF_CRC_TAPS 9'h03c
`define NTF_CRC_INV 9'h1eb
`endif

/* File: test/ntf_props.sv */
// Port assertions for the NRZI tape block formatter
`timescale 1ns/1ns
`default_nettype none
module ntf_props #(
  parameter CHAR_CYC_800 = 8
) (
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic        avs_read_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [1:0]  tape_sel_o,
  input wire logic        tape_wr_strobe_o,
  input wire logic        tape_gap_o,
  input wire logic [8:0]  tape_rd_i,
  input wire logic        tape_rd_strobe_i,
  input wire logic [7:0]  rd_data_o,
  input wire logic        rd_strobe_o,
  input wire logic        hard_err_o,
  input wire logic        block_end_o,
  input wire logic        file_mark_o
);
  logic [15:0] sil;
  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // =====
  // Cycles since the last tape character
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || tape_rd_strobe_i)
      sil <= 16'h0;
    else if (sil != 16'hffff)
      sil <= sil + 16'h1;
  end
  function automatic logic [5:0] low6(input logic [8:0] c);
    low6 = {c[2], c[3], c[4], c[5], c[6], c[7]};
  endfunction
  sequence rd_taken;
    tape_rd_strobe_i;
  endsequence
  sequence rd_given;
    ##1 rd_strobe_o;
  endsequence
  sequence bus_read;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  // =====
  // Assertions
  rd_echo_a: assert property (rd_taken |-> rd_given)
    else $error("no read strobe after a tape character");
  rd_cause_a: assert property (rd_strobe_o |-> $past(tape_rd_strobe_i))
    else $error("read strobe without a tape character");
  rd_map_a: assert property (rd_strobe_o |-> rd_data_o[5:0] == low6($past(tape_rd_i)))
    else $error("read byte low bits not mapped from channels");
  rd_msb_a: assert property (rd_strobe_o && rd_data_o[7:6] != 2'h0 |->
    rd_data_o[7:6] == {$past(tape_rd_i[0]), $past(tape_rd_i[1])})
    else $error("read byte top bits not from channels 0 and 1");
  err_width_a: assert property (hard_err_o |-> rd_strobe_o)
    else $error("hard error outside the read strobe");
  mark_end_a: assert property (file_mark_o |-> block_end_o)
    else $error("file mark without block end");
  blk_sil_a: assert property (block_end_o |-> sil >= 25 * CHAR_CYC_800)
    else $error("block end before the silence limit");
  wr_pulse_a: assert property (tape_wr_strobe_o |=> !tape_wr_strobe_o [*7])
    else $error("write characters closer than one character period");
  rd_wait_a: assert property ($rose(avs_read_i) |-> bus_read)
    else $error("register read not answered in the second cycle");
  rd_upper_a: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  rst_quiet_a: assert property (disable iff (1'b0) sys_rst_i |=> !tape_wr_strobe_o && !rd_strobe_o
    && !tape_gap_o && tape_sel_o == 2'h0)
    else $error("outputs active after reset");
endmodule
bind ntf_formatter ntf_props #(.CHAR_CYC_800(CHAR_CYC_800)) props_u (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .tape_sel_o(tape_sel_o), .tape_wr_strobe_o(tape_wr_strobe_o), .tape_gap_o(tape_gap_o),
  .tape_rd_i(tape_rd_i), .tape_rd_strobe_i(tape_rd_strobe_i), .rd_data_o(rd_data_o),
  .rd_strobe_o(rd_strobe_o), .hard_err_o(hard_err_o), .block_end_o(block_end_o),
  .file_mark_o(file_mark_o)
);
`default_nettype wire

/* File: test/ntf_tape_model.sv */
// Tape read electronics: echoes written characters, injects bench characters
`timescale 1ns/1ns
`default_nettype none
module ntf_tape_model (
  input  wire logic       clk_sys_i,
  input  wire logic [8:0] wr_char_i,
  input  wire logic       wr_stb_i,
  input  wire logic [8:0] inj_char_i,
  input  wire logic       inj_i,
  output var  logic [8:0] rd_char_o,
  output var  logic       rd_stb_o
);
  logic [8:0] last;
  initial begin
    last = 9'h0;
    rd_char_o = 9'h1ff;
    rd_stb_o = 1'b0;
  end
  // Between strobes the lines show the inverse of the last character
  always @(posedge clk_sys_i) begin
    rd_stb_o <= inj_i || wr_stb_i;
    if (inj_i || wr_stb_i) begin
      rd_char_o <= inj_i ? inj_char_i : wr_char_i;
      last <= inj_i ? inj_char_i : wr_char_i;
    end else begin
      rd_char_o <= ~last;
    end
  end
endmodule
`default_nettype wire

/* File: test/test_nrzi_tape_block_formatter.sv */
// Self-checking bench for the NRZI tape block formatter
`timescale 1ns/1ns
`default_nettype none
`include "ntf_defines.vh"
`define CHK_EQ(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module test_nrzi_tape_block_formatter;
  localparam int CC2 = 16;
  localparam int CC5 = 10;
  localparam int CC8 = 8;
  logic        clk, rst, rd, wr, wt, wstb, gap, trs, rds, herr, bend, fmk, inj;
  logic [4:0]  adr;
  logic [31:0] wd, rdat, q;
  logic [3:0]  be;
  logic [1:0]  sel;
  logic [8:0]  two, trd, injc;
  logic [7:0]  rdd;
  logic [7:0]  dat [4];
  logic [8:0]  wq [$];
  int          tq [$], gq [$];
  int          failures, samples_checked, cyc, gl, n_rd, n_he, n_fm, n_be, s, f0, h0;
  ntf_formatter #(.CHAR_CYC_200(CC2), .CHAR_CYC_556(CC5), .CHAR_CYC_800(CC8),
    .GAP_FM_CYC(40), .GAP_IBG7_CYC(20), .GAP_IBG9_CYC(16)) dut_u (
    .clk_sys_i(clk), .sys_rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .tape_sel_o(sel), .tape_wr_o(two), .tape_wr_strobe_o(wstb),
    .tape_gap_o(gap), .tape_rd_i(trd), .tape_rd_strobe_i(trs), .rd_data_o(rdd),
    .rd_strobe_o(rds), .hard_err_o(herr), .block_end_o(bend), .file_mark_o(fmk));
  ntf_tape_model mdl_u (.clk_sys_i(clk), .wr_char_i(two), .wr_stb_i(wstb),
    .inj_char_i(injc), .inj_i(inj), .rd_char_o(trd), .rd_stb_o(trs));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // =====
  // Port monitor
  always @(posedge clk) begin
    cyc++;
    if (wstb === 1'b1) begin
      wq.push_back(two);
      tq.push_back(cyc);
    end
    if (gap !== 1'b1 && gl != 0) gq.push_back(gl);
    gl = (gap === 1'b1) ? gl + 1 : 0;
    n_rd += (rds === 1'b1);
    n_he += (herr === 1'b1);
    n_fm += (fmk === 1'b1);
    n_be += (bend === 1'b1);
  end
  // =====
  // Expected characters
  function automatic logic [8:0] enc(input logic [7:0] d, input bit nine, input bit ev);
    enc = 9'h0;
    for (int j = 0; j < (nine ? 8 : 6); j++) enc[7 - j] = d[j];
    enc[8] = (^enc[7:0]) ^ !ev;
  endfunction
  function automatic logic [8:0] crc(input int n);
    logic m;
    crc = 9'h0;
    for (int i = 0; i < n; i++) begin
      crc = crc ^ enc(dat[i], 1, 0);
      m = crc[8];
      crc = {crc[7:0], m};
      if (m) crc[5:2] = ~crc[5:2];
    end
    crc = crc ^ `NTF_CRC_INV;
  endfunction
  // =====
  // Bus and sequence tasks
  task automatic bus(input bit w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
    end while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(0, a, 32'h0);
    `CHK_EQ("reg", e, q & m)
  endtask
  task automatic wait_end();
    int n;
    n = 0;
    f0 = n_be;
    while (n_be == f0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) failures++;
    repeat (4) @(posedge clk);
  endtask
  task automatic put(input logic [8:0] c, input int t);
    repeat (t * CC8) @(posedge clk);
    injc <= c;
    inj <= 1'b1;
    @(posedge clk);
    inj <= 1'b0;
  endtask
  task automatic dblk(input bit nine, input bit ev, input logic [1:0] dn, input int n,
                      input int cc);
    int i, r0;
    logic [8:0] x;
    wq.delete();
    tq.delete();
    r0 = n_rd;
    x = 9'h0;
    bus(1, `NTF_REG_CTRL, {28'h0, dn, ev, nine});
    bus(1, `NTF_REG_WDATA, {24'h0, dat[0]});
    bus(1, `NTF_REG_CMD, 32'h1);
    for (i = 1; i < n; i++) bus(1, `NTF_REG_WDATA, {24'h0, dat[i]});
    bus(1, `NTF_REG_CMD, 32'h4);
    wait_end();
    foreach (wq[j]) x ^= wq[j];
    `CHK_EQ("count", n + (nine ? 2 : 1), wq.size())
    `CHK_EQ("echo", wq.size(), n_rd - r0)
    for (i = 0; i < n; i++) `CHK_EQ("char", enc(dat[i], nine, ev), wq[i])
    `CHK_EQ("track", 9'h0, x)
    `CHK_EQ("check gap", 4 * cc, tq[n] - tq[n - 1])
    if (nine) begin
      `CHK_EQ("crc", crc(n), wq[n])
      `CHK_EQ("lrc gap", 4 * cc, tq[n + 1] - tq[n])
      `CHK_EQ("lrc zero", 1'b1, wq[n + 1] != 9'h0)
    end
  endtask
  task automatic fm(input bit nine, input int cc);
    logic [8:0] p;
    p = nine ? `NTF_FM9 : `NTF_FM7;
    wq.delete();
    tq.delete();
    gq.delete();
    h0 = n_fm;
    s = n_he;
    bus(1, `NTF_REG_CTRL, {31'h0, nine});
    bus(1, `NTF_REG_CMD, 32'h3);
    wait_end();
    `CHK_EQ("mark chars", 2, wq.size())
    `CHK_EQ("mark", p, wq[0])
    `CHK_EQ("mark check", p, wq[1])
    `CHK_EQ("mark gap", (nine ? 8 : 4) * cc, tq[1] - tq[0])
    `CHK_EQ("pre gap", 1'b1, gq[0] >= 40)
    `CHK_EQ("post gap", 1'b1, gq[1] >= (nine ? 16 : 20))
    `CHK_EQ("mark seen", h0 + 1, n_fm)
    `CHK_EQ("mark err", s + !nine, n_he)
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  // =====
  // Tests
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 5'h0;
    wd = 32'h0;
    be = 4'hf;
    inj = 1'b0;
    injc = 9'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk(`NTF_REG_CTRL, 32'hff, {24'h0, `NTF_CTRL_RST});
    for (s = 0; s < 4; s++) begin
      bus(1, `NTF_REG_CTRL, s << 4);
      rchk(`NTF_REG_CTRL, 32'h3f, s << 4);
      `CHK_EQ("select", s[1:0], sel)
    end
    be <= 4'h0;
    bus(1, `NTF_REG_CTRL, 32'h10);
    be <= 4'hf;
    rchk(`NTF_REG_CTRL, 32'h3f, 32'h30);
    rchk(`NTF_REG_CMD, 32'hffffffff, 32'h0);
    rchk(5'h14, 32'hffffffff, 32'h0);
    $display("test registers done");
    dat = '{8'h00, 8'ha5, 8'hff, 8'h3c};
    dblk(1, 0, 2'h0, 4, CC8);
    rchk(`NTF_REG_STATUS, 32'h2c, 32'h0);
    dat = '{8'h2a, 8'h15, 8'h3f, 8'h01};
    for (s = 0; s < 3; s++) dblk(0, s[0], s[1:0], 3, s == 0 ? CC2 : s == 1 ? CC5 : CC8);
    dblk(1, 0, 2'h0, 2, CC8);
    rchk(`NTF_REG_STATUS, 32'h8, 32'h8);
    bus(1, `NTF_REG_CMD, 32'h9);
    repeat (3 * CC8) @(posedge clk);
    for (s = 0; s < 3; s++) bus(1, `NTF_REG_WDATA, {24'h0, dat[s]});
    bus(1, `NTF_REG_CMD, 32'h4);
    wait_end();
    rchk(`NTF_REG_STATUS, 32'hc, 32'h4);
    $display("test data blocks done");
    fm(1, CC8);
    fm(0, CC2);
    $display("test file marks done");
    bus(1, `NTF_REG_CTRL, 32'h8);
    bus(1, `NTF_REG_CMD, 32'h8);
    h0 = n_he;
    s = n_fm;
    put(9'h0f8, 1);
    put(9'h0f8, 4);
    wait_end();
    `CHK_EQ("five channel mark", s, n_fm)
    `CHK_EQ("good parity", h0, n_he)
    rchk(`NTF_REG_RDATA, 32'hff, 32'h1f);
    rchk(`NTF_REG_STATUS, 32'h50, 32'h0);
    put(enc(8'h01, 0, 0), 1);
    put(enc(8'h02, 0, 0) ^ 9'h100, 1);
    put(enc(8'h03, 0, 0), 1);
    put(enc(8'h01, 0, 0) ^ enc(8'h02, 0, 0) ^ enc(8'h03, 0, 0) ^ 9'h100, 4);
    wait_end();
    `CHK_EQ("bad parity", h0 + 1, n_he)
    rchk(`NTF_REG_STATUS, 32'h30, 32'h10);
    bus(1, `NTF_REG_CMD, 32'h8);
    rchk(`NTF_REG_STATUS, 32'hff, 32'h0);
    $display("test read checks done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
